// File: common/tsm_params.svh
// Register offsets, reset values, key values and timing counts of the tilt bank
`ifndef TSM_PARAMS_SVH
`define TSM_PARAMS_SVH

// Register offsets (register numbers on the link)
`define TSM_OFS_X_AXIS_TILT       16'h0001
`define TSM_OFS_Y_AXIS_TILT       16'h0002
`define TSM_OFS_SIGNED_HALF_TURN  16'h0003
`define TSM_OFS_UNSIGNED_FULL     16'h0004
`define TSM_OFS_LINE_SPEED        16'h000a
`define TSM_OFS_PARITY            16'h000b
`define TSM_OFS_STOP_BITS         16'h000c
`define TSM_OFS_SLAVE_ADDRESS     16'h000d
`define TSM_OFS_SAVE_CONFIG       16'h0032
`define TSM_OFS_DEVICE_RESTART    16'h0034

// Factory values
`define TSM_RST_LINE_SPEED        16'h0004
`define TSM_RST_PARITY            16'h0002
`define TSM_RST_STOP_BITS         16'h0001
`define TSM_RST_SLAVE_ADDRESS     16'h0064

// Legal code ranges
`define TSM_SPEED_MIN             16'h0001
`define TSM_SPEED_MAX             16'h0005
`define TSM_PARITY_MIN            16'h0001
`define TSM_PARITY_MAX            16'h0003
`define TSM_PARITY_NONE           16'h0001
`define TSM_STOP_MIN              16'h0001
`define TSM_STOP_MAX              16'h0002
`define TSM_ADDR_MIN              16'h0001
`define TSM_ADDR_MAX              16'h00f7

// Key that commits the configuration to the nonvolatile store
`define TSM_SAVE_KEY              16'h5354

// Full turn in hundredths of a degree
`define TSM_FULL_TURN             17'h08ca0

// Timing: clock rate, bits per character, silence in half characters
`define TSM_CLK_HZ                64'd20000000
`define TSM_CHAR_BITS             64'd11
`define TSM_SILENCE_HALF_CHARS    64'd7
`define TSM_BAUD_1                64'd2400
`define TSM_BAUD_2                64'd4800
`define TSM_BAUD_3                64'd9600
`define TSM_BAUD_4                64'd19200
`define TSM_BAUD_5                64'd38400
// Least silence in clock cycles, rounded up
`define TSM_SILENCE_CYC(b) \
  ((`TSM_CLK_HZ * `TSM_CHAR_BITS * `TSM_SILENCE_HALF_CHARS \
    + 64'd2 * (b) - 64'd1) / (64'd2 * (b)))

`endif

// File: common/tsm_pkg.sv
// Types shared by the tilt sensor register bank
package tsm_pkg;

  // Serial link configuration as kept in the bank and in the store
  typedef struct packed {
    logic [15:0] line_speed_select;
    logic [15:0] parity_select;
    logic [15:0] stop_bit_count;
    logic [15:0] slave_address;
  } tsm_cfg_t;

  // Effective character format handed to the serial engine
  typedef struct packed {
    logic [2:0]  speed_code;
    logic [1:0]  parity_code;
    logic        two_stop_bits;
    logic [7:0]  node_address;
    logic [19:0] silence_cycles;
  } tsm_link_t;

  // Measured angles in hundredths of a degree
  typedef struct packed {
    logic [15:0] x_tilt;
    logic [15:0] y_tilt;
  } tsm_angle_t;

  // Register access from the protocol engine
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] addr;
    logic [15:0] wdata;
  } tsm_req_t;

  typedef enum logic [1:0] {
    TSM_ST_LOAD_REQ  = 2'b00,
    TSM_ST_LOAD_WAIT = 2'b01,
    TSM_ST_RUN       = 2'b10
  } tsm_state_t;

endpackage

// File: src/tsm_register_bank.sv
// Holding-register bank of a serial-link tilt sensor
`timescale 1ns/1ps
`default_nettype none
`include "tsm_params.svh"

// Behaviour
// - Factory link is 19200, 8E1
// - Speed codes 1..5, default code 4
// - Parity codes 1..3, default even
// - Even or odd parity forces one stop
// - No parity honours one or two stops
// - Address 1..247, default 100
// - Key 0x5354 saves configuration to store
// - Saved changes apply only after restart
// - Holding-register reads return register contents
// - Register 3 signed tilt, 0.01 degree
// - Register 4 unsigned tilt, 0 to 360
// - Registers 1, 2 dual-axis signed tilts
// - Load configuration from store at power-up
// - Three and half character silence between frames
module tsm_register_bank
  import tsm_pkg::*;
#(
  // Unit variant: two axes when set, one axis otherwise
  parameter bit          DUAL_AXIS    = 1'b0,
  // Least bus silence in clock cycles for speed codes 1 to 5
  parameter logic [19:0] SILENCE_SP1  = 20'(`TSM_SILENCE_CYC(`TSM_BAUD_1)),
  parameter logic [19:0] SILENCE_SP2  = 20'(`TSM_SILENCE_CYC(`TSM_BAUD_2)),
  parameter logic [19:0] SILENCE_SP3  = 20'(`TSM_SILENCE_CYC(`TSM_BAUD_3)),
  parameter logic [19:0] SILENCE_SP4  = 20'(`TSM_SILENCE_CYC(`TSM_BAUD_4)),
  parameter logic [19:0] SILENCE_SP5  = 20'(`TSM_SILENCE_CYC(`TSM_BAUD_5))
)
(
  input  wire logic       clk,
  input  wire logic       srst,
  // Register port from the protocol engine
  input  wire tsm_req_t   reg_req,
  output var  logic       reg_ack,
  output var  logic       reg_err,
  output var  logic [15:0] reg_rdata,
  // Angle feed from the measurement logic
  input  wire tsm_angle_t angle_in,
  input  wire logic       angle_valid,
  // Nonvolatile store handshake
  output var  logic       store_load_req,
  input  wire logic       store_load_valid,
  input  wire tsm_cfg_t   store_load_data,
  output var  logic       store_save_req,
  output var  tsm_cfg_t   store_save_data,
  // Restart strobe and format handed to the serial engine
  output var  logic       restart_pulse,
  output var  logic       link_ready,
  output var  tsm_link_t  link_cfg
);

  tsm_state_t  state;
  tsm_state_t  next_state;
  tsm_cfg_t    bank;
  tsm_cfg_t    next_bank;
  tsm_angle_t  angle;
  tsm_link_t   next_link;

  // Range checks on written values
  wire         speed_ok  = reg_req.wdata >= `TSM_SPEED_MIN &&
                           reg_req.wdata <= `TSM_SPEED_MAX;
  wire         parity_ok = reg_req.wdata >= `TSM_PARITY_MIN &&
                           reg_req.wdata <= `TSM_PARITY_MAX;
  wire         stop_ok   = reg_req.wdata >= `TSM_STOP_MIN &&
                           reg_req.wdata <= `TSM_STOP_MAX;
  wire         addr_ok   = reg_req.wdata >= `TSM_ADDR_MIN &&
                           reg_req.wdata <= `TSM_ADDR_MAX;

  // Address decode
  wire         hit_x     = reg_req.addr == `TSM_OFS_X_AXIS_TILT;
  wire         hit_y     = reg_req.addr == `TSM_OFS_Y_AXIS_TILT;
  wire         hit_half  = reg_req.addr == `TSM_OFS_SIGNED_HALF_TURN;
  wire         hit_full  = reg_req.addr == `TSM_OFS_UNSIGNED_FULL;
  wire         hit_speed = reg_req.addr == `TSM_OFS_LINE_SPEED;
  wire         hit_par   = reg_req.addr == `TSM_OFS_PARITY;
  wire         hit_stop  = reg_req.addr == `TSM_OFS_STOP_BITS;
  wire         hit_addr  = reg_req.addr == `TSM_OFS_SLAVE_ADDRESS;
  wire         hit_save  = reg_req.addr == `TSM_OFS_SAVE_CONFIG;
  wire         hit_rst   = reg_req.addr == `TSM_OFS_DEVICE_RESTART;
  wire         hit_ro    = hit_x || hit_y || hit_half || hit_full;
  wire         hit_rw    = hit_speed || hit_par || hit_stop || hit_addr;
  wire         hit_wo    = hit_save || hit_rst;
  // Writes outside the run state are refused with an error, so the reload never overwrites one
  wire         wr        = reg_req.valid && reg_req.write &&
                           state == TSM_ST_RUN;
  wire         rd        = reg_req.valid && !reg_req.write;

  // Write effects
  wire         do_save   = wr && hit_save &&
                           reg_req.wdata == `TSM_SAVE_KEY;
  wire         do_restart = wr && hit_rst;
  wire         bad_value = (hit_speed && !speed_ok) ||
                           (hit_par && !parity_ok) ||
                           (hit_stop && !stop_ok) ||
                           (hit_addr && !addr_ok);
  wire         bad_write = reg_req.write && (hit_ro || bad_value ||
                           (hit_save && !do_save) ||
                           state != TSM_ST_RUN);
  wire         bad_read  = !reg_req.write && (hit_wo || !(hit_ro || hit_rw));
  wire         unmapped  = !(hit_ro || hit_rw || hit_wo);

  // Full-turn view of the single-axis tilt
  wire  [16:0] half_ext  = {angle.x_tilt[15], angle.x_tilt};
  wire  [16:0] full_sum  = half_ext + `TSM_FULL_TURN;
  wire  [15:0] full_turn = angle.x_tilt[15] ? full_sum[15:0]
                                            : angle.x_tilt;

  // Read data selection; a single-axis unit keeps the X tilt in slot 3
  // Slots of the other unit variant read as zero without an error
  wire  [15:0] read_mux =
    (hit_x && DUAL_AXIS)     ? angle.x_tilt :
    (hit_y && DUAL_AXIS)     ? angle.y_tilt :
    (hit_half && !DUAL_AXIS) ? angle.x_tilt :
    (hit_full && !DUAL_AXIS) ? full_turn    :
    hit_speed                ? bank.line_speed_select :
    hit_par                  ? bank.parity_select :
    hit_stop                 ? bank.stop_bit_count :
    hit_addr                 ? bank.slave_address : 16'h0000;

  // Validated copy of what the store returns; bad fields fall to factory
  tsm_cfg_t    loaded;
  assign loaded.line_speed_select =
    (store_load_data.line_speed_select >= `TSM_SPEED_MIN &&
     store_load_data.line_speed_select <= `TSM_SPEED_MAX)
      ? store_load_data.line_speed_select : `TSM_RST_LINE_SPEED;
  assign loaded.parity_select =
    (store_load_data.parity_select >= `TSM_PARITY_MIN &&
     store_load_data.parity_select <= `TSM_PARITY_MAX)
      ? store_load_data.parity_select : `TSM_RST_PARITY;
  assign loaded.stop_bit_count =
    (store_load_data.stop_bit_count >= `TSM_STOP_MIN &&
     store_load_data.stop_bit_count <= `TSM_STOP_MAX)
      ? store_load_data.stop_bit_count : `TSM_RST_STOP_BITS;
  // A blank or corrupt store can never give address zero
  assign loaded.slave_address =
    (store_load_data.slave_address >= `TSM_ADDR_MIN &&
     store_load_data.slave_address <= `TSM_ADDR_MAX)
      ? store_load_data.slave_address : `TSM_RST_SLAVE_ADDRESS;

  // Next bank contents: load from store, or accept in-range writes
  always_comb
  begin
    next_bank = bank;
    if (state == TSM_ST_LOAD_WAIT && store_load_valid)
    begin
      next_bank = loaded;
    end
    else if (wr && !bad_value)
    begin
      if (hit_speed)
        next_bank.line_speed_select = reg_req.wdata;
      if (hit_par)
        next_bank.parity_select = reg_req.wdata;
      if (hit_stop)
        next_bank.stop_bit_count = reg_req.wdata;
      if (hit_addr)
        next_bank.slave_address = reg_req.wdata;
    end
  end

  // Effective link format built from the freshly loaded configuration
  // Saved bank writes reach the link only on the next load, so the master
  // keeps talking in the old format until a restart
  always_comb
  begin
    next_link = link_cfg;
    if (state == TSM_ST_LOAD_WAIT && store_load_valid)
    begin
      next_link.speed_code   = loaded.line_speed_select[2:0];
      next_link.parity_code  = loaded.parity_select[1:0];
      next_link.two_stop_bits =
        loaded.parity_select == `TSM_PARITY_NONE &&
        loaded.stop_bit_count == `TSM_STOP_MAX;
      next_link.node_address = loaded.slave_address[7:0];
      case (loaded.line_speed_select[2:0])
        3'h1:    next_link.silence_cycles = SILENCE_SP1;
        3'h2:    next_link.silence_cycles = SILENCE_SP2;
        3'h3:    next_link.silence_cycles = SILENCE_SP3;
        3'h5:    next_link.silence_cycles = SILENCE_SP5;
        default: next_link.silence_cycles = SILENCE_SP4;
      endcase
    end
  end

  // Start-up and restart sequencing
  always_comb
  begin
    next_state = state;
    case (state)
      TSM_ST_LOAD_REQ:
        next_state = TSM_ST_LOAD_WAIT;
      TSM_ST_LOAD_WAIT:
        // Stay until the store has answered
        if (store_load_valid)
          next_state = TSM_ST_RUN;
      TSM_ST_RUN:
        // A restart goes back through the full reload
        if (do_restart)
          next_state = TSM_ST_LOAD_REQ;
      default:
        next_state = TSM_ST_LOAD_REQ;
    endcase
  end

  // Sequencer and bank; factory bank until the store answers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state <= TSM_ST_LOAD_REQ;
      bank  <= '{`TSM_RST_LINE_SPEED, `TSM_RST_PARITY,
                 `TSM_RST_STOP_BITS, `TSM_RST_SLAVE_ADDRESS};
    end
    else
    begin
      state    <= next_state;
      bank     <= next_bank;
    end
  end

  // Factory character format, in force from reset to the first load
  wire tsm_link_t factory_link = '{
    speed_code:     3'(`TSM_RST_LINE_SPEED),
    parity_code:    2'(`TSM_RST_PARITY),
    two_stop_bits:  1'b0,
    node_address:   8'(`TSM_RST_SLAVE_ADDRESS),
    silence_cycles: SILENCE_SP4
  };

  // Character format register
  always_ff @(posedge clk)
  begin
    if (srst)
      link_cfg <= factory_link;
    else
      link_cfg <= next_link;
  end

  // Angle capture from the measurement logic
  // Held between samples so both axes always come from one sample
  always_ff @(posedge clk)
  begin
    if (srst)
      angle <= '0;
    else if (angle_valid)
      angle <= angle_in;
  end

  // Register port answer, one cycle after the request
  // Read data is zero on writes and errors, so no stale value leaks
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      reg_ack   <= 1'b0;
      reg_err   <= 1'b0;
      reg_rdata <= 16'h0000;
    end
    else
    begin
      reg_ack   <= reg_req.valid;
      reg_err   <= reg_req.valid && (unmapped || bad_write || bad_read);
      reg_rdata <= rd ? read_mux : 16'h0000;
    end
  end

  // Store load request and link status
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      store_load_req <= 1'b0;
      link_ready     <= 1'b0;
    end
    else
    begin
      // High for the first wait cycle, and for the request state only on a restart; not held until the store answers
      store_load_req <= next_state == TSM_ST_LOAD_REQ ||
                        (state == TSM_ST_LOAD_REQ);
      link_ready     <= next_state == TSM_ST_RUN;
    end
  end

  // Save and restart strobes
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      store_save_req  <= 1'b0;
      store_save_data <= '0;
      restart_pulse   <= 1'b0;
    end
    else
    begin
      store_save_req <= do_save;
      if (do_save)
        store_save_data <= bank;
      restart_pulse  <= do_restart;
    end
  end

endmodule
`default_nettype wire

// File: verification/tb.sv
// Self-checking bench for the tilt register bank
`timescale 1ns/1ps
`default_nettype none
module tb
  import tsm_pkg::*;
;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  tsm_req_t    req = '0;
  tsm_angle_t  ang = '0;
  logic        ang_v = 1'b0;
  logic [3:0]  lat = 4'h2;
  logic        ack, err, ld_req, ld_v, sv_req, rdy;
  logic [15:0] rd;
  tsm_cfg_t    ld_d, sv_d;
  tsm_link_t   cfg;
  logic [16:0] exp_q[$];
  logic [16:0] e;
  tsm_req_t    req2 = '0;
  logic        ack2, err2, rsp;
  logic [15:0] rd2, yv;
  logic [16:0] exp2_q[$];
  logic [16:0] e2;
  tsm_link_t   held;
  int          errors = 0;
  int          compares = 0;
  int          i, x;
  tsm_register_bank #(.SILENCE_SP1(20'd21), .SILENCE_SP2(20'd22),
    .SILENCE_SP3(20'd23), .SILENCE_SP4(20'd24), .SILENCE_SP5(20'd25)) dut (
    .clk(clk), .srst(srst), .reg_req(req), .reg_ack(ack), .reg_err(err),
    .reg_rdata(rd), .angle_in(ang), .angle_valid(ang_v),
    .store_load_req(ld_req), .store_load_valid(ld_v),
    .store_load_data(ld_d), .store_save_req(sv_req),
    .store_save_data(sv_d), .restart_pulse(rsp), .link_ready(rdy),
    .link_cfg(cfg));
  tsm_store_model u_store (.clk(clk), .srst(srst), .lat(lat),
    .load_req(ld_req), .load_valid(ld_v), .load_data(ld_d),
    .save_req(sv_req), .save_data(sv_d));
  // Dual-axis unit on the same store and angle feed
  tsm_register_bank #(.DUAL_AXIS(1'b1)) dut2 (
    .clk(clk), .srst(srst), .reg_req(req2), .reg_ack(ack2), .reg_err(err2),
    .reg_rdata(rd2), .angle_in(ang), .angle_valid(ang_v),
    .store_load_req(), .store_load_valid(ld_v), .store_load_data(ld_d),
    .store_save_req(), .store_save_data(), .restart_pulse(),
    .link_ready(), .link_cfg());
  always #25 clk = ~clk;
  // Take the oldest expected dual-axis answer off its queue at each ack
  always @(negedge clk)
    if (ack2 === 1'b1)
    begin
      e2 = exp2_q.size() ? exp2_q.pop_front() : 17'h1ffff;
      compares++;
      if ({err2, rd2} !== e2)
      begin
        errors++;
        $display("BAD %0t dual reply %h want %h", $time, {err2, rd2}, e2);
      end
    end
  // Take the oldest expected answer off the queue at each ack
  always @(negedge clk)
    if (ack === 1'b1)
    begin
      e = exp_q.size() ? exp_q.pop_front() : 17'h1ffff;
      compares++;
      if ({err, rd} !== e)
      begin
        errors++;
        $display("BAD %0t reply %h want %h", $time, {err, rd}, e);
      end
    end
  task automatic give_verdict();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [63:0] g, input logic [63:0] w);
    compares++;
    if (g !== w)
    begin
      errors++;
      $display("BAD %0t got %h want %h", $time, g, w);
    end
  endtask
  // One access per falling edge; requests may follow back to back
  task automatic acc(input logic w, input logic [15:0] ad, dt,
                     input logic xe, input logic [15:0] xr);
    @(negedge clk);
    req <= '{1'b1, w, ad, dt};
    exp_q.push_back({xe, xr});
  endtask
  task automatic idle();
    @(negedge clk);
    req.valid <= 1'b0;
    req2.valid <= 1'b0;
  endtask
  // Read on the dual-axis unit; a run of them is followed by idle
  task automatic acc2(input logic [15:0] ad, input logic [15:0] xr);
    @(negedge clk);
    req2 <= '{1'b1, 1'b0, ad, 16'h0000};
    exp2_q.push_back({1'b0, xr});
  endtask
  // Effective format expected for a given bank content
  function automatic logic [63:0] lk(input logic [15:0] s, p, t, a);
    return {s[2:0], p[1:0], p == 16'h1 && t == 16'h2, a[7:0],
            20'd20 + 20'(s)};
  endfunction
  task automatic wait_rdy();
    for (int n = 0; n < 300 && rdy !== 1'b1; n++)
      @(negedge clk);
  endtask
  task automatic defs(input logic [15:0] s, p, t, a);
    acc(0, 16'h000a, 0, 0, s);
    acc(0, 16'h000b, 0, 0, p);
    acc(0, 16'h000c, 0, 0, t);
    acc(0, 16'h000d, 0, 0, a);
    idle();
  endtask
  // Write, save, restart, then check the format in force
  task automatic round(input logic [15:0] s, p, t, a);
    logic [63:0] old;
    old = 64'(cfg);
    acc(1, 16'h000a, s, 0, 0);
    acc(1, 16'h000b, p, 0, 0);
    acc(1, 16'h000c, t, 0, 0);
    acc(1, 16'h000d, a, 0, 0);
    acc(0, 16'h000d, 0, 0, a);
    acc(1, 16'h0032, 16'h5353, 1, 0);
    acc(1, 16'h0032, 16'h5354, 0, 0);
    idle();
    chk(sv_d, {s, p, t, a});
    chk(cfg, old);
    lat <= 4'($urandom_range(1, 8));
    acc(1, 16'h0034, 0, 0, 0);
    idle();
    chk(rdy, 0);
    chk(rsp, 1);
    acc(1, 16'h000a, 16'h0001, 1, 0);
    idle();
    wait_rdy();
    chk(cfg, lk(s, p, t, a));
  endtask
  initial
  begin
    #2000000;
    errors++;
    give_verdict();
  end
  initial
  begin
    void'($urandom(53980));
    repeat (6) @(negedge clk);
    srst <= 1'b0;
    wait_rdy();
    chk(cfg, lk(4, 2, 1, 100));
    defs(4, 2, 1, 100);
    for (i = 0; i < 4; i++)
    begin
      x = (i == 0) ? -3317 : int'($urandom_range(36000)) - 18000;
      @(negedge clk);
      yv = 16'($urandom);
      ang <= '{16'(x), yv};
      ang_v <= 1'b1;
      @(negedge clk);
      ang_v <= 1'b0;
      acc(0, 16'h0003, 0, 0, 16'(x));
      acc(0, 16'h0004, 0, 0, 16'(x < 0 ? x + 36000 : x));
      acc(0, 16'h0001, 0, 0, 0);
      idle();
      acc2(16'h0001, 16'(x));
      acc2(16'h0002, yv);
      acc2(16'h0003, 0);
      idle();
    end
    acc(1, 16'h000a, 16'h0000, 1, 0);
    acc(1, 16'h000a, 16'h0006, 1, 0);
    acc(1, 16'h000b, 16'h0004, 1, 0);
    acc(1, 16'h000d, 16'h0000, 1, 0);
    acc(1, 16'h000d, 16'h00f8, 1, 0);
    acc(1, 16'h0003, 16'h0001, 1, 0);
    acc(0, 16'h0005, 0, 1, 0);
    defs(4, 2, 1, 100);
    for (i = 1; i < 6; i++)
    begin
      acc(1, 16'h000a, 16'(i), 0, 0);
      acc(0, 16'h000a, 0, 0, 16'(i));
      acc(1, 16'h000b, 16'(i % 3 + 1), 0, 0);
    end
    idle();
    round(3, 1, 2, 247);
    round(5, 3, 2, 1);
    // Random legal speed and address, even parity, one stop; the single node keeps a nonzero unique address
    round(16'($urandom_range(1, 5)), 2, 1,
          16'($urandom_range(1, 247)));
    held = cfg;
    srst <= 1'b1;
    repeat (2) @(negedge clk);
    chk(cfg, lk(4, 2, 1, 100));
    chk(rdy, 0);
    srst <= 1'b0;
    wait_rdy();
    chk(cfg, held);
    repeat (3) @(negedge clk);
    chk(exp_q.size(), 0);
    chk(exp2_q.size(), 0);
    give_verdict();
  end
endmodule
`default_nettype wire

// File: verification/tsm_bank_properties.sv
// Port checks on the tilt register bank
`timescale 1ns/1ps
`default_nettype none
module tsm_bank_props
  import tsm_pkg::*;
(
  input wire logic      clk,
  input wire logic      srst,
  input wire tsm_req_t  reg_req,
  input wire logic      reg_ack,
  input wire logic      reg_err,
  input wire logic      store_load_valid,
  input wire logic      store_save_req,
  input wire logic      restart_pulse,
  input wire logic      link_ready,
  input wire tsm_link_t link_cfg
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Decoded write requests
  wire wr  = reg_req.valid && reg_req.write;
  wire sav = wr && reg_req.addr == 16'h0032;
  wire key = reg_req.wdata == 16'h5354;
  wire bad = wr && reg_req.addr == 16'h000a && reg_req.wdata > 16'h0005;
  wire rst = wr && reg_req.addr == 16'h0034 && link_ready;
  // Answer timing and side effects of accesses
  property p_ack; reg_req.valid |=> reg_ack; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_key; sav && key && link_ready |=> store_save_req; endproperty
  a_key: assert property (p_key) else $error("no save");
  property p_nokey; sav && !key |=> !store_save_req && reg_err; endproperty
  a_nokey: assert property (p_nokey) else $error("bad save");
  property p_bad; bad |=> reg_err; endproperty
  a_bad: assert property (p_bad) else $error("speed taken");
  property p_rst; rst |=> restart_pulse && !link_ready; endproperty
  a_rst: assert property (p_rst) else $error("no restart");
  // Effective link format only moves on a load
  property p_hold; !store_load_valid |=> $stable(link_cfg); endproperty
  a_hold: assert property (p_hold) else $error("cfg moved");
  property p_stop; link_cfg.parity_code != 2'h1 |-> !link_cfg.two_stop_bits;
  endproperty
  a_stop: assert property (p_stop) else $error("two stops");
  property p_rng; link_ready |-> link_cfg.speed_code inside {[1:5]}
    && link_cfg.node_address != 8'h00; endproperty
  a_rng: assert property (p_rng) else $error("bad cfg");
  c_save: cover property (sav && key ##1 store_save_req);
  c_rst: cover property (restart_pulse);
  c_two: cover property (link_cfg.two_stop_bits);
endmodule
bind tsm_register_bank tsm_bank_props u_props (.clk(clk), .srst(srst),
  .reg_req(reg_req), .reg_ack(reg_ack), .reg_err(reg_err),
  .store_load_valid(store_load_valid), .store_save_req(store_save_req),
  .restart_pulse(restart_pulse), .link_ready(link_ready),
  .link_cfg(link_cfg));
`default_nettype wire

// File: verification/tsm_store_model.sv
// Nonvolatile configuration store facing the bank
`timescale 1ns/1ps
`default_nettype none
module tsm_store_model
  import tsm_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [3:0] lat,
  input  wire logic       load_req,
  output var  logic       load_valid,
  output var  tsm_cfg_t   load_data,
  input  wire logic       save_req,
  input  wire tsm_cfg_t   save_data
);
  tsm_cfg_t   mem = '{16'h0004, 16'h0002, 16'h0001, 16'h0064};
  logic       req_q = 1'b0;
  logic       busy = 1'b0;
  logic [3:0] cnt = 4'h0;
  // Released data lines show the inverse of the content
  assign load_data = load_valid ? mem : ~mem;
  // Answer a new load lat+1 cycles after the edge that first sees the request; content survives reset
  always_ff @(posedge clk)
  begin
    req_q <= load_req;
    cnt <= (load_req && !req_q) ? lat : cnt - 4'h1;
    load_valid <= !srst && busy && cnt == 4'h0;
    if (srst || (busy && cnt == 4'h0))
      busy <= 1'b0;
    else if (load_req && !req_q)
      busy <= 1'b1;
    if (save_req)
      mem <= save_data;
  end
endmodule
`default_nettype wire
